// ---- hw/battery_monitor_config_status.sv ----
// Configuration and status register bank of the battery monitor
// Assumes a bit-level bus engine that decodes commands and whole bytes,
// a charger core that reports progress, and a 10 MHz clock
`timescale 1ns/100ps
`include "bms_defines.svh"
module battery_monitor_config_status
    import bms_pkg::*;
#(
    parameter int unsigned SLEEP_CYCLES = `SLEEP_LOW_CYCLES,
    parameter int unsigned EE_PROG_CYCLES = `EE_PROG_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Shared data line, open drain
    input wire logic dq_i,
    output logic dq_o,
    output logic dq_oe,
    input wire logic dq_pull_low,
    // Decoded commands and memory bytes from the bus engine
    input wire cmd_s cmd,
    input wire mem_wr_s mem_wr,
    input wire logic rd_req,
    input wire logic [7:0] rd_addr,
    output logic rd_valid,
    output logic [7:0] rd_data,
    // Network layer support
    output logic [7:0] read_id_opcode,
    output logic [63:0] net_address,
    output logic bus_reset,
    output logic sleep_mode,
    // Charger core
    input wire logic charge_supply_input,
    input wire logic charging,
    input wire logic charge_complete,
    output logic charge_start_req,
    output logic charge_stop_req,
    output logic nimh_select
);

    ////////////////////////////////////////////////////////////////////////////

    localparam logic [24:0] SLEEP_CNT = 25'(SLEEP_CYCLES);
    localparam logic [24:0] BUS_RESET_CNT = 25'(`BUS_RESET_CYCLES);
    localparam logic [31:0] EE_LAST = 32'(EE_PROG_CYCLES - 1);
    localparam logic [7:0] STATUS_OFF = `EE_STATUS_INIT_ADDR - `EE_FIRST_ADDR;

    // Address lies in lockable EEPROM
    function automatic logic in_ee(input logic [7:0] a);
        return (a >= `EE_FIRST_ADDR) && (a <= `EE_LAST_ADDR);
    endfunction

    // Block number of an EEPROM address
    function automatic logic [1:0] blk_of(input logic [7:0] a);
        if (a < `EE_BLK1_ADDR)
            return 2'h0;
        else if (a < `EE_BLK2_ADDR)
            return 2'h1;
        else
            return 2'h2;
    endfunction

    logic dq_sync;
    logic supply_sync;
    logic [24:0] lo_cnt_r;
    logic bus_reset_r;
    logic sleep_r;
    logic load_pend_r;
    logic [7:0] cfg_r;
    logic done_r;
    logic [1:0] charge_state;
    logic [7:0] status_byte;
    logic [7:0] control_byte;
    logic supply_prev_r;
    logic start_r;
    logic stop_r;
    ee_state_e ee_state_r;
    logic [31:0] ee_cnt_r;
    logic [1:0] ee_blk_r;
    logic [2:0] locked_r;
    logic lock_en_r;
    logic [7:0] shadow_r [`EE_BYTES];
    logic [7:0] ee_r [`EE_BYTES];
    logic [7:0] wr_off;
    logic [7:0] rd_off;
    logic [7:0] rd_mux;
    logic rd_valid_r;
    logic [7:0] rd_data_r;
    logic status_wr;
    logic control_wr;
    logic refresh;
    logic cmd_blk_ok;
    logic copy_go;
    logic lock_go;
    logic recall_go;
    logic ee_done;
    logic ee_wr_ok;
    logic copy_busy;

    ////////////////////////////////////////////////////////////////////////////

    // Pins from outside the clock domain
    pin_sync #(.RESET_VAL(1'b1)) u_dq_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .pin(dq_i),
        .level(dq_sync)
    );

    pin_sync #(.RESET_VAL(1'b0)) u_supply_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .pin(charge_supply_input),
        .level(supply_sync)
    );

    net_address_rom u_net_address
    (
        .clk(clk),
        .rst_n(rst_n),
        .net_address(net_address)
    );

    assign dq_o = 1'b0;
    assign dq_oe = dq_pull_low;

    ////////////////////////////////////////////////////////////////////////////

    // Length of the current low period, saturating
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lo_cnt_r <= 25'h0;
        else if (dq_sync)
            lo_cnt_r <= 25'h0;
        else if (lo_cnt_r != SLEEP_CNT)
            lo_cnt_r <= lo_cnt_r + 25'h1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            bus_reset_r <= 1'b0;
        else
            bus_reset_r <= !dq_sync && (lo_cnt_r == BUS_RESET_CNT);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            sleep_r <= 1'b0;
        else if (cfg_r[`CS_SLEEP_EN] && dq_sync)
            sleep_r <= 1'b0;
        else if (cfg_r[`CS_SLEEP_EN] && (lo_cnt_r == SLEEP_CNT))
            sleep_r <= 1'b1;
    end

    assign bus_reset = bus_reset_r;
    assign sleep_mode = sleep_r;

    ////////////////////////////////////////////////////////////////////////////

    // Decoded accesses
    assign status_wr = mem_wr.valid && (mem_wr.addr == `REG_CHARGE_CONFIG_STATUS);
    assign control_wr = mem_wr.valid && (mem_wr.addr == `REG_EEPROM_CONTROL);
    assign refresh = cmd.valid && (cmd.opcode == `OP_REFRESH);

    // Power-up load one cycle after reset release
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            load_pend_r <= 1'b1;
        else
            load_pend_r <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cfg_r <= `CS_RESET;
        else if (load_pend_r || refresh)
            cfg_r <= ee_r[STATUS_OFF[5:0]] & `CS_CFG_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            done_r <= 1'b0;
        else if (charge_complete)
            done_r <= 1'b1;
        else if (status_wr)
            done_r <= 1'b0;
    end

    always_comb
    begin
        if (done_r)
            charge_state = `CHG_DONE;
        else if (charging)
            charge_state = `CHG_RUNNING;
        else if (supply_sync)
            charge_state = `CHG_SOURCE;
        else
            charge_state = `CHG_NONE;
    end

    assign status_byte = {charge_state, cfg_r[5:0]};

    assign read_id_opcode = cfg_r[`CS_READ_ID_SEL] ? `OP_READ_ID_1 : `OP_READ_ID_0;

    assign nimh_select = cfg_r[`CS_CHEMISTRY];

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            supply_prev_r <= 1'b0;
            start_r <= 1'b0;
            stop_r <= 1'b0;
        end
        else
        begin
            supply_prev_r <= supply_sync;
            start_r <= (cmd.valid && (cmd.opcode == `OP_START_CHARGE))
                || (cfg_r[`CS_START_SRC] && supply_sync && !supply_prev_r);
            stop_r <= cmd.valid && (cmd.opcode == `OP_STOP_CHARGE);
        end
    end

    assign charge_start_req = start_r;
    assign charge_stop_req = stop_r;

    ////////////////////////////////////////////////////////////////////////////

    // Command acceptance for the EEPROM engine
    assign cmd_blk_ok = cmd.valid && in_ee(cmd.addr) && !locked_r[blk_of(cmd.addr)];
    assign copy_go = cmd_blk_ok && (cmd.opcode == `OP_COPY) && (ee_state_r == EE_IDLE);
    assign lock_go = cmd_blk_ok && (cmd.opcode == `OP_LOCK) && lock_en_r
        && (ee_state_r == EE_IDLE);
    assign recall_go = cmd.valid && in_ee(cmd.addr) && (cmd.opcode == `OP_RECALL)
        && (ee_state_r == EE_IDLE);
    assign ee_done = (ee_state_r != EE_IDLE) && (ee_cnt_r == EE_LAST);
    assign copy_busy = (ee_state_r == EE_COPY);

    // Programming engine for copy and lock
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ee_state_r <= EE_IDLE;
            ee_cnt_r <= 32'h0;
            ee_blk_r <= 2'h0;
        end
        else
        begin
            case (ee_state_r)
                EE_IDLE:
                begin
                    ee_cnt_r <= 32'h0;
                    ee_blk_r <= blk_of(cmd.addr);
                    if (copy_go)
                        ee_state_r <= EE_COPY;
                    else if (lock_go)
                        ee_state_r <= EE_LOCK;
                end
                EE_COPY, EE_LOCK:
                begin
                    if (ee_cnt_r == EE_LAST)
                        ee_state_r <= EE_IDLE;
                    else
                        ee_cnt_r <= ee_cnt_r + 32'h1;
                end
                default:
                    ee_state_r <= EE_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            locked_r <= 3'h0;
        else if (ee_done && (ee_state_r == EE_LOCK))
            locked_r[ee_blk_r] <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            lock_en_r <= 1'b0;
        else if (control_wr)
            lock_en_r <= mem_wr.data[`EC_LOCK_EN];
        else if (cmd.valid)
            lock_en_r <= 1'b0;
    end

    assign control_byte = {copy_busy, lock_en_r, 3'h0, locked_r};

    ////////////////////////////////////////////////////////////////////////////

    assign wr_off = mem_wr.addr - `EE_FIRST_ADDR;
    assign ee_wr_ok = mem_wr.valid && in_ee(mem_wr.addr)
        && !locked_r[blk_of(mem_wr.addr)] && !copy_busy;

    // Shadow and EEPROM bytes, one pair per entry
    for (genvar i = 0; i < `EE_BYTES; i++)
    begin : g_ee
        localparam logic [1:0] BLK = 2'(i / `EE_BLK_BYTES);

        // Shadow byte: recall or host write
        always_ff @(posedge clk)
        begin
            if (!rst_n)
                shadow_r[i] <= 8'h00;
            else if (recall_go && (blk_of(cmd.addr) == BLK))
                shadow_r[i] <= ee_r[i];
            else if (ee_wr_ok && (wr_off[5:0] == 6'(i)))
                shadow_r[i] <= mem_wr.data;
        end

        // Non-volatile byte: end of copy
        always_ff @(posedge clk)
        begin
            if (!rst_n)
                ee_r[i] <= 8'h00;
            else if (ee_done && copy_busy && (ee_blk_r == BLK))
                ee_r[i] <= shadow_r[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Read data selection
    assign rd_off = rd_addr - `EE_FIRST_ADDR;

    always_comb
    begin
        if (rd_addr == `REG_CHARGE_CONFIG_STATUS)
            rd_mux = status_byte;
        else if (rd_addr == `REG_EEPROM_CONTROL)
            rd_mux = control_byte;
        else if (in_ee(rd_addr))
            rd_mux = shadow_r[rd_off[5:0]];
        else
            rd_mux = 8'h00;
    end

    // Read answer one cycle after request
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
        end
        else
        begin
            rd_valid_r <= rd_req;
            if (rd_req)
                rd_data_r <= rd_mux;
        end
    end

    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_copy_accept;
        cmd.valid && (cmd.opcode == `OP_COPY) && cmd_blk_ok && (ee_state_r == EE_IDLE);
    endsequence

    sequence s_copy_running;
        copy_busy [*2];
    endsequence

    AST_CHARGE_CODE: assert property (
        (charging && !done_r) |-> (rd_mux[7:6] == `CHG_RUNNING) || (rd_addr != 8'h01))
        else $error("charging not reported as 01");

    AST_DONE_HOLD: assert property (
        (status_byte[7:6] == `CHG_DONE) && !status_wr |=> (status_byte[7:6] == `CHG_DONE))
        else $error("finished state lost without a status write");

    AST_SLEEP_ENTRY: assert property (
        cfg_r[`CS_SLEEP_EN] && !dq_sync && (lo_cnt_r == SLEEP_CNT) |=> sleep_mode)
        else $error("sleep not entered after long low");

    AST_SLEEP_DISABLED: assert property (
        !cfg_r[`CS_SLEEP_EN] |=> $stable(sleep_mode))
        else $error("sleep changed while disabled");

    AST_START_SOURCE: assert property (
        !cfg_r[`CS_START_SRC] && !(cmd.valid && (cmd.opcode == `OP_START_CHARGE))
        |=> !charge_start_req)
        else $error("charge started without command");

    AST_REFRESH_LOAD: assert property (
        refresh |=> (cfg_r == (ee_r[STATUS_OFF[5:0]] & `CS_CFG_MASK)))
        else $error("refresh did not load EEPROM byte");

    AST_COPY_BUSY: assert property (
        s_copy_accept |=> s_copy_running)
        else $error("copy flag not raised");

    AST_COPY_BLOCKS_WRITE: assert property (
        copy_busy |-> !ee_wr_ok)
        else $error("EEPROM write accepted during copy");

    AST_LOCK_NEEDS_EN: assert property (
        cmd.valid && (cmd.opcode == `OP_LOCK) && !lock_en_r && (ee_state_r == EE_IDLE)
        |=> (ee_state_r == EE_IDLE))
        else $error("lock ran without enable");

    AST_LOCK_EN_CLEAR: assert property (
        cmd.valid && !control_wr |=> !lock_en_r)
        else $error("lock enable survived a command");

    AST_LOCK_FLAG: assert property (
        ee_done && (ee_state_r == EE_LOCK) |=> locked_r[$past(ee_blk_r)])
        else $error("lock flag not set");

    AST_BUS_RESET: assert property (
        bus_reset |-> ($past(lo_cnt_r) == BUS_RESET_CNT) && !$past(dq_sync))
        else $error("bus reset without long low");

    AST_OPEN_DRAIN: assert property (
        (dq_oe == dq_pull_low) && !dq_o)
        else $error("line driven other than open drain");

endmodule // battery_monitor_config_status

// ---- hw/bms_defines.svh ----
// Constants of the battery monitor configuration and status bank
// Assumes a 10 MHz system clock and byte-wide register addresses
`ifndef BMS_DEFINES_SVH
`define BMS_DEFINES_SVH

// Clock rate
`define CLK_FREQ_MHZ 10

// Register addresses
`define REG_CHARGE_CONFIG_STATUS 8'h01
`define REG_EEPROM_CONTROL 8'h07

// Lockable EEPROM layout
`define EE_FIRST_ADDR 8'h20
`define EE_LAST_ADDR 8'h47
`define EE_BLK1_ADDR 8'h30
`define EE_BLK2_ADDR 8'h40
`define EE_STATUS_INIT_ADDR 8'h31
`define EE_BYTES 40
`define EE_BLK_BYTES 16

// Status register fields
`define CS_CHARGE_HI 7
`define CS_CHARGE_LO 6
`define CS_SLEEP_EN 5
`define CS_READ_ID_SEL 4
`define CS_START_SRC 1
`define CS_CHEMISTRY 0
`define CS_CFG_MASK 8'h33
`define CS_RESET 8'h00

// Charge condition codes
`define CHG_NONE 2'h0
`define CHG_RUNNING 2'h1
`define CHG_SOURCE 2'h2
`define CHG_DONE 2'h3

// EEPROM control register fields
`define EC_COPY_BUSY 7
`define EC_LOCK_EN 6

// Command opcodes
`define OP_READ_ID_0 8'h33
`define OP_READ_ID_1 8'h39
`define OP_COPY 8'h48
`define OP_RECALL 8'hb8
`define OP_LOCK 8'h6a
`define OP_REFRESH 8'h63
`define OP_START_CHARGE 8'hb5
`define OP_STOP_CHARGE 8'hbe

// Timing: bus reset low time, sleep low time, EEPROM programming time
`define BUS_RESET_US 120
`define BUS_RESET_CYCLES (`BUS_RESET_US * `CLK_FREQ_MHZ)
`define SLEEP_LOW_MS 2000
`define SLEEP_LOW_CYCLES (`SLEEP_LOW_MS * 1000 * `CLK_FREQ_MHZ)
`define EE_PROG_US 10000
`define EE_PROG_CYCLES (`EE_PROG_US * `CLK_FREQ_MHZ)

`endif

// ---- hw/bms_pkg.sv ----
// Types shared by the battery monitor configuration and status bank
// Assumes nothing beyond byte-wide commands and addresses
package bms_pkg;

    // Decoded function command with its address byte
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [7:0] addr;
    } cmd_s;

    // One complete byte written by the host
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } mem_wr_s;

    // EEPROM programming engine
    typedef enum logic [1:0] {EE_IDLE, EE_COPY, EE_LOCK} ee_state_e;

endpackage

// ---- hw/net_address_rom.sv ----
// Fixed 64-bit net address: family code, serial number, check byte
// Assumes the check byte is programmed together with the serial
`timescale 1ns/100ps
module net_address_rom #(
    // Arbitrary neutral values
    parameter logic [7:0] FAMILY_CODE = 8'h5a,
    parameter logic [47:0] SERIAL_NUMBER = 48'h0123_4567_89ab,
    parameter logic [7:0] ADDR_CRC = 8'h00
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Address, family code in the low byte
    output logic [63:0] net_address
);

    logic [63:0] addr_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            addr_r <= {ADDR_CRC, SERIAL_NUMBER, FAMILY_CODE};
    end

    assign net_address = addr_r;

    // Address never changes once out of reset
    AST_NET_ADDR_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
        net_address == {ADDR_CRC, SERIAL_NUMBER, FAMILY_CODE})
        else $error("net address differs from its fixed value");

endmodule // net_address_rom

// ---- hw/pin_sync.sv ----
// Three-stage synchroniser for a pin from outside the clock domain
// Assumes a slowly changing level; a change counts once stages agree
`timescale 1ns/100ps
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin and clean level
    input wire logic pin,
    output logic level
);

    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // Sampling chain
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept a new level only when the last two stages agree
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            level_r <= RESET_VAL;
        else if (s2_r == s3_r)
            level_r <= s3_r;
    end

    assign level = level_r;

endmodule // pin_sync

// ---- test/battery_monitor_config_status_test.sv ----
// Self-checking bench of the battery monitor configuration and status bank
// Assumes the host model issues requests; this bench drives charger and pins
`timescale 1ns/100ps
module battery_monitor_config_status_test
    import bms_pkg::*;
;
    // Design connections
    logic clk, rst_n, dq_o, dq_oe, dq_pull_low, host_low, rd_req, rd_valid;
    logic bus_reset, sleep_mode, charge_supply_input, charging, charge_complete;
    logic charge_start_req, charge_stop_req, nimh_select;
    logic [7:0] rd_addr, rd_data, read_id_opcode;
    logic [63:0] net_address;
    wire logic dq_i;
    cmd_s cmd;
    mem_wr_s mem_wr;
    int n_fail = 0, compares = 0, n_start = 0, n_stop = 0, n_rst = 0, cyc = 0;

    ////////////////////////////////////////
    // Clock, 100 ns period
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Wired level: pull-up unless a party pulls low
    assign dq_i = !(host_low || dq_oe);

    battery_monitor_config_status #(.SLEEP_CYCLES(3000), .EE_PROG_CYCLES(8))
        battery_monitor_config_status_inst (.clk, .rst_n, .dq_i, .dq_o, .dq_oe,
        .dq_pull_low, .cmd, .mem_wr, .rd_req, .rd_addr, .rd_valid, .rd_data,
        .read_id_opcode, .net_address, .bus_reset, .sleep_mode,
        .charge_supply_input, .charging, .charge_complete, .charge_start_req,
        .charge_stop_req, .nimh_select);

    host_master_model host_master_model_inst (.clk, .cmd, .mem_wr, .rd_req,
        .rd_addr, .rd_valid, .rd_data, .host_low);

    // Count pulses and cut a hang short
    always @(posedge clk)
    begin
        n_start += int'(charge_start_req);
        n_stop += int'(charge_stop_req);
        n_rst += int'(bus_reset);
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    ////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Register read with answer check
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic ok;
        logic [7:0] d;
        host_master_model_inst.rd(a, ok, d);
        check(ok, 1'b1, "no read answer");
        check(d, exp, "read data");
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_master_model_inst.wr(a, d);
    endtask

    task automatic op(input logic [7:0] o, input logic [7:0] a);
        host_master_model_inst.op(o, a);
    endtask

    // Values after reset, address layout, unmapped place
    task automatic t_defaults;
        logic [7:0] crc;
        rdchk(8'h01, 8'h00);
        rdchk(8'h07, 8'h00);
        wr(8'h05, 8'hff);
        rdchk(8'h05, 8'h00);
        check(read_id_opcode, 8'h33, "opcode default");
        check(nimh_select, 1'b0, "chemistry default");
        check(net_address[7:0], 8'h5a, "family code");
        check(net_address[55:8], 48'h0123_4567_89ab, "serial");
        crc = host_master_model_inst.crc8(net_address[55:0]);
        if (crc !== net_address[63:56])
            rdchk(8'h01, 8'h00);
    endtask

    // Long and short low periods, sleep, open-drain drive
    task automatic t_line(input logic sl);
        int r0;
        r0 = n_rst;
        host_master_model_inst.pull(1'b1);
        repeat (1150) @(negedge clk);
        host_master_model_inst.pull(1'b0);
        repeat (10) @(negedge clk);
        check(n_rst - r0, 0, "short low");
        host_master_model_inst.pull(1'b1);
        repeat (3100) @(negedge clk);
        check(n_rst - r0, 1, "bus reset");
        check(sleep_mode, sl, "sleep entry");
        host_master_model_inst.pull(1'b0);
        repeat (10) @(negedge clk);
        check(sleep_mode, 1'b0, "wake");
        dq_pull_low = !dq_oe;
        @(negedge clk);
        check({dq_oe, dq_o, dq_i}, 3'b100, "open drain");
        dq_pull_low = !dq_oe;
        @(negedge clk);
        check({dq_oe, dq_i}, 2'b01, "released");
    endtask

    // Charge states, start sources, held finished state
    task automatic t_charge(input int src, input logic [7:0] cfg);
        int s0;
        int s1;
        s0 = n_start;
        s1 = n_stop;
        charging = 1'b1;
        repeat (3) @(negedge clk);
        rdchk(8'h01, cfg | 8'h40);
        charging = 1'b0;
        charge_supply_input = 1'b1;
        repeat (8) @(negedge clk);
        check(n_start - s0, src, "supply start");
        rdchk(8'h01, cfg | 8'h80);
        op(8'hb5, 8'h00);
        op(8'hbe, 8'h00);
        repeat (2) @(negedge clk);
        check(n_start - s0, src + 1, "start command");
        check(n_stop - s1, 1, "stop command");
        check(nimh_select, cfg[0], "chemistry");
        charge_complete = 1'b1;
        @(negedge clk);
        charge_complete = 1'b0;
        charge_supply_input = 1'b0;
        repeat (8) @(negedge clk);
        rdchk(8'h01, cfg | 8'hc0);
        wr(8'h01, 8'h5a);
        rdchk(8'h01, cfg);
    endtask

    // Write while busy, refresh from the array not the shadow
    task automatic t_config;
        wr(8'h31, 8'h33);
        op(8'h48, 8'h30);
        rdchk(8'h07, 8'h80);
        wr(8'h21, 8'h55);
        repeat (12) @(negedge clk);
        rdchk(8'h07, 8'h00);
        rdchk(8'h21, 8'h00);
        wr(8'h21, 8'h66);
        rdchk(8'h21, 8'h66);
        wr(8'h31, 8'h00);
        op(8'h63, 8'h00);
        rdchk(8'h01, 8'h33);
        check(read_id_opcode, 8'h39, "opcode select");
    endtask

    task automatic t_lock;
        op(8'h6a, 8'h20);
        repeat (12) @(negedge clk);
        rdchk(8'h07, 8'h00);
        wr(8'h07, 8'h40);
        rdchk(8'h07, 8'h40);
        op(8'h63, 8'h00);
        rdchk(8'h07, 8'h00);
        wr(8'h07, 8'h40);
        op(8'h6a, 8'h30);
        rdchk(8'h07, 8'h00);
        repeat (12) @(negedge clk);
        rdchk(8'h07, 8'h02);
        wr(8'h31, 8'hff);
        rdchk(8'h31, 8'h00);
        wr(8'h22, 8'h77);
        rdchk(8'h22, 8'h77);
    endtask

    // Verdict and end of run
    task automatic end_of_test;
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////
    // Reset, then scenarios in order
    initial
    begin
        rst_n = 1'b0;
        dq_pull_low = 1'b0;
        charge_supply_input = 1'b0;
        charging = 1'b0;
        charge_complete = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        t_defaults();
        t_line(1'b0);
        t_charge(0, 8'h00);
        t_config();
        t_charge(1, 8'h33);
        t_lock();
        t_line(1'b1);
        end_of_test();
    end
endmodule // battery_monitor_config_status_test

// ---- test/host_master_model.sv ----
// Host side model: bus engine requests and the master's pull on the data line
// Assumes requests change at the falling edge and are sampled at the rising edge
`timescale 1ns/100ps
module host_master_model
    import bms_pkg::*;
(
    // Clock
    input wire logic clk,
    // Requests to the bank
    output cmd_s cmd,
    output mem_wr_s mem_wr,
    output logic rd_req,
    output logic [7:0] rd_addr,
    // Read answer
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    // Master pull on the data line
    output logic host_low
);
    ////////////////////////////////////////
    // idle line released
    initial
    begin
        cmd = '0;
        mem_wr = '0;
        rd_req = 1'b0;
        rd_addr = 8'h00;
        host_low = 1'b0;
    end

    // One byte write, strobe for one cycle, then stale fields inverted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        mem_wr = '{1'b1, a, d};
        @(negedge clk);
        mem_wr = '{1'b0, ~a, ~d};
    endtask

    // commands follow caller order, never gated on check byte
    task automatic op(input logic [7:0] o, input logic [7:0] a);
        @(negedge clk);
        cmd = '{1'b1, o, a};
        @(negedge clk);
        cmd = '{1'b0, ~o, ~a};
    endtask

    // Read, answer taken one cycle after the request
    task automatic rd(input logic [7:0] a, output logic ok, output logic [7:0] d);
        @(negedge clk);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge clk);
        rd_req = 1'b0;
        rd_addr = ~a;
        ok = rd_valid;
        d = rd_data;
    endtask

    // pull low or release to idle high
    task automatic pull(input logic v);
        @(negedge clk);
        host_low = v;
    endtask

    // check byte, low bit first, x^8+x^5+x^4+1
    function automatic logic [7:0] crc8(input logic [55:0] v);
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
        begin
            fb = c[0] ^ v[i];
            c = (c >> 1) ^ (fb ? 8'h8c : 8'h00);
        end
        return c;
    endfunction
endmodule // host_master_model
